/* File: lds_ctrl_defines.vh */
// Constants for the LED driver serial control block: address, fields, resets and timing.
`ifndef LDS_CTRL_DEFINES_VH
`define LDS_CTRL_DEFINES_VH

// ----------------------------------------------------------------------------
// Bus address
// ----------------------------------------------------------------------------
// Fixed 7-bit slave address, binary 0011011.
`define LDS_SLAVE_ADDR      7'h1B
// Direction bit value that means a write.
`define LDS_DIR_WRITE       1'b0
// Number of data bytes in one complete set.
`define LDS_DATA_BYTES      2'h3

// ----------------------------------------------------------------------------
// Field positions in the auxiliary level and option byte and in the camera level byte
// ----------------------------------------------------------------------------
// Auxiliary level occupies bits 1..0.
`define LDS_AUX_MSB         1
`define LDS_AUX_LSB         0
// Short dropout delay option bit.
`define LDS_SHORT_DLY_BIT   2
// Forced pump mode field occupies bits 4..3.
`define LDS_FORCE_MSB       4
`define LDS_FORCE_LSB       3
// Camera field split inside the camera level byte.
`define LDS_CAM_HI_MSB      7
`define LDS_CAM_HI_LSB      4
`define LDS_CAM_LO_MSB      3
`define LDS_CAM_LO_LSB      0

// ----------------------------------------------------------------------------
// Pump mode codes and reset values
// ----------------------------------------------------------------------------
`define LDS_MODE_1X         2'h0
`define LDS_MODE_1X5        2'h1
`define LDS_MODE_2X         2'h2
`define LDS_RST_LEVEL       8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// Core clock rate in MHz.
`define LDS_CLK_MHZ         125
// Normal and short dropout qualification delays in microseconds.
`define LDS_DLY_LONG_US     150000
`define LDS_DLY_SHORT_US    2000
// Glitch filter length in core clock cycles (32 ns at 125 MHz).
`define LDS_FILT_CYC        4

`endif

/* File: lds_serial_ctrl.v */
// Two-wire write-only slave with data latching and charge pump mode control.
`include "lds_ctrl_defines.vh"

// What this block does
// - Camera level picks low or high field
// - Level select high shortens delay to 2ms
// - Level select falling returns pump to 1x in automatic mode
// - Over-temperature disables sources and pump while active
// - Current-set fault disables sources and pump
// - Qualified dropout steps 1x to 1.5x to 2x
// - Dropout must persist the qualification delay
// - Short-delay option bit selects 2ms delay
// - Any serial data update sets pump to 1x, or to the forced mode if one is set
// - Forced pump mode stops automatic switching
// - Receive only, never transmits data
// - Works to 400kHz, filters line glitches
// - Detects START and STOP conditions
// - Eight bits MSB first, then acknowledge clock
// - Holds SDA low through acknowledge high phase
// - Answers only address 0011011
// - Read request to our address is ignored
// - Address then three data bytes, each acknowledged
// - Byte enters holding latch at its acknowledge
// - Complete set survives repeated STARTs, applied at STOP
// - Early STOP ignored, last complete set kept
// - Re-addressed: STOP ignored until new set complete
// - Valid STOP loads holding latches into DACs
// - Zero group disabled, all zero means shutdown
module lds_serial_ctrl
#(
    parameter DLY_LONG_CYC  = `LDS_DLY_LONG_US * `LDS_CLK_MHZ,
    parameter DLY_SHORT_CYC = `LDS_DLY_SHORT_US * `LDS_CLK_MHZ
)
(
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire       camera_level_select,
    input  wire       over_temp,
    input  wire       current_set_fault,
    input  wire       dropout,
    output reg  [7:0] main_dac,
    output reg        main_en,
    output reg  [3:0] cam_dac,
    output reg        cam_en,
    output reg  [1:0] aux_dac,
    output reg        aux_en,
    output reg  [1:0] pump_mode,
    output reg        pump_en,
    output reg        shutdown,
    output reg        load_pulse
);

    // ------------------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------------------
    localparam CW = $clog2(DLY_LONG_CYC + 1);   // Dropout counter width.

    // Receiver states.
    localparam [2:0] ST_IDLE = 3'h0;             // Waiting for START.
    localparam [2:0] ST_ADDR = 3'h1;             // Shifting the address byte.
    localparam [2:0] ST_DATA = 3'h2;             // Shifting a data byte.
    localparam [2:0] ST_ACK  = 3'h3;             // Driving the acknowledge bit.
    localparam [2:0] ST_SKIP = 3'h4;             // Not ours, or set complete; wait for START/STOP.

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [5:0]    sync1_r;        // First synchroniser stage, read only by stage two.
    reg  [5:0]    sync2_r;        // Second stage: {scl, sda, cam, ot, rf, drop}.
    reg           scl_f_r;        // Filtered clock line.
    reg           sda_f_r;        // Filtered data line.
    reg  [2:0]    scl_cnt_r;      // Clock line stability counter.
    reg  [2:0]    sda_cnt_r;      // Data line stability counter.
    reg           scl_d_r;        // Filtered clock, one cycle late.
    reg           sda_d_r;        // Filtered data, one cycle late.
    reg  [2:0]    state_r;        // Receiver state.
    reg  [3:0]    bit_cnt_r;      // Bits shifted in the current byte.
    reg  [1:0]    byte_cnt_r;     // Data bytes acknowledged so far.
    reg  [7:0]    shift_r;        // Incoming byte shift register.
    reg  [7:0]    stage0_r;       // Holding latch, first data byte.
    reg  [7:0]    stage1_r;       // Holding latch, second data byte.
    reg  [7:0]    hold_main_r;    // Last complete set, main level.
    reg  [7:0]    hold_cam_r;     // Last complete set, camera levels.
    reg  [7:0]    hold_aux_r;     // Last complete set, auxiliary and options.
    reg           full_r;         // A complete set awaits a STOP.
    reg  [7:0]    main_led_level_r;           // Applied main level.
    reg  [7:0]    camera_led_levels_r;        // Applied camera levels.
    reg  [7:0]    aux_level_and_options_r;    // Applied auxiliary and options.
    reg  [1:0]    mode_r;         // Current pump mode.
    reg           auto_r;         // Automatic mode switching allowed.
    reg  [CW-1:0] dly_cnt_r;      // Dropout persistence counter.
    reg           cam_d_r;        // Level select, one cycle late.

    wire scl_s   = sync2_r[5];
    wire sda_s   = sync2_r[4];
    wire cam_sel = sync2_r[3];
    wire fault   = sync2_r[2] | sync2_r[1];
    wire drop_s  = sync2_r[0];
    wire scl_rise = scl_f_r & ~scl_d_r;
    wire scl_fall = ~scl_f_r & scl_d_r;
    wire start_det = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
    wire stop_det  = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;
    wire short_dly = cam_sel | aux_level_and_options_r[`LDS_SHORT_DLY_BIT];
    wire [CW-1:0] dly_lim = short_dly ? DLY_SHORT_CYC[CW-1:0]
                                      : DLY_LONG_CYC[CW-1:0];
    wire all_zero = (main_led_level_r == `LDS_RST_LEVEL)
                  & (camera_led_levels_r == `LDS_RST_LEVEL)
                  & (aux_level_and_options_r[`LDS_AUX_MSB:`LDS_AUX_LSB] == 2'h0);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Every pin passes two flip-flops before anything looks at it.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= 6'h30;
            sync2_r <= 6'h30;
        end
        else
        begin
            sync1_r <= {scl, sda_in, camera_level_select, over_temp, current_set_fault, dropout};
            sync2_r <= sync1_r;
        end
    end

    // ------------------------------------------------------------------------
    // Glitch filters
    // ------------------------------------------------------------------------
    // A line changes its filtered level only after it has held the new level
    // for the filter length, so short spikes on a corrupted bus are dropped.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_f_r   <= 1'b1;
            sda_f_r   <= 1'b1;
            scl_cnt_r <= 3'h0;
            sda_cnt_r <= 3'h0;
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_f_r;
            // Clock line filter.
            if (scl_s == scl_f_r)
                scl_cnt_r <= 3'h0;
            else if (scl_cnt_r == `LDS_FILT_CYC - 1)
            begin
                scl_f_r   <= scl_s;
                scl_cnt_r <= 3'h0;
            end
            else
                scl_cnt_r <= scl_cnt_r + 3'h1;
            // Data line filter.
            if (sda_s == sda_f_r)
                sda_cnt_r <= 3'h0;
            else if (sda_cnt_r == `LDS_FILT_CYC - 1)
            begin
                sda_f_r   <= sda_s;
                sda_cnt_r <= 3'h0;
            end
            else
                sda_cnt_r <= sda_cnt_r + 3'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------------------
    // Bits are taken on the clock rising edge; the acknowledge is driven from
    // the falling edge after the eighth bit until the next falling edge, so
    // the line is steady low for the whole high phase of the ninth clock.
    // The only value ever driven is low: the block never sends data.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            byte_cnt_r  <= 2'h0;
            shift_r     <= 8'h00;
            stage0_r    <= 8'h00;
            stage1_r    <= 8'h00;
            hold_main_r <= 8'h00;
            hold_cam_r  <= 8'h00;
            hold_aux_r  <= 8'h00;
            full_r      <= 1'b0;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
            load_pulse  <= 1'b0;
            main_led_level_r        <= `LDS_RST_LEVEL;
            camera_led_levels_r     <= `LDS_RST_LEVEL;
            aux_level_and_options_r <= `LDS_RST_LEVEL;
        end
        else
        begin
            sda_out    <= 1'b0;
            load_pulse <= 1'b0;
            if (start_det)
            begin
                // START or repeated START: a held complete set stays armed.
                state_r   <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe    <= 1'b0;
            end
            else if (stop_det)
            begin
                state_r <= ST_IDLE;
                sda_oe  <= 1'b0;
                // Only a complete set is applied; otherwise STOP is ignored.
                if (full_r)
                begin
                    main_led_level_r        <= hold_main_r;
                    camera_led_levels_r     <= hold_cam_r;
                    aux_level_and_options_r <= hold_aux_r;
                    load_pulse              <= 1'b1;
                    full_r                  <= 1'b0;
                end
            end
            else
            begin
                case (state_r)
                    ST_ADDR, ST_DATA:
                    begin
                        // Shift in most significant bit first.
                        if (scl_rise)
                        begin
                            shift_r   <= {shift_r[6:0], sda_f_r};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_r == 4'h8)
                        begin
                            if (state_r == ST_ADDR)
                            begin
                                if (shift_r[7:1] == `LDS_SLAVE_ADDR &&
                                    shift_r[0] == `LDS_DIR_WRITE)
                                begin
                                    sda_oe     <= 1'b1;
                                    state_r    <= ST_ACK;
                                    byte_cnt_r <= 2'h0;
                                    full_r     <= 1'b0;
                                end
                                else
                                    state_r <= ST_SKIP;
                            end
                            else
                            begin
                                // Latch the byte as its acknowledge starts.
                                sda_oe     <= 1'b1;
                                state_r    <= ST_ACK;
                                byte_cnt_r <= byte_cnt_r + 2'h1;
                                case (byte_cnt_r)
                                    2'h0:    stage0_r <= shift_r;
                                    2'h1:    stage1_r <= shift_r;
                                    default:
                                    begin
                                        hold_main_r <= stage0_r;
                                        hold_cam_r  <= stage1_r;
                                        hold_aux_r  <= shift_r;
                                        full_r      <= 1'b1;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        // Release after the acknowledge clock; extra bytes go unanswered.
                        if (scl_fall)
                        begin
                            sda_oe    <= 1'b0;
                            bit_cnt_r <= 4'h0;
                            state_r   <= (byte_cnt_r == `LDS_DATA_BYTES) ? ST_SKIP : ST_DATA;
                        end
                    end
                    ST_SKIP:
                        sda_oe <= 1'b0;
                    default:
                        sda_oe <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Charge pump mode sequencing
    // ------------------------------------------------------------------------
    // A new data set restarts at 1x or jumps to a forced mode; in automatic
    // mode a dropout held for the full delay steps the pump up one mode.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r    <= `LDS_MODE_1X;
            auto_r    <= 1'b1;
            dly_cnt_r <= {CW{1'b0}};
            cam_d_r   <= 1'b0;
        end
        else
        begin
            cam_d_r <= cam_sel;
            if (load_pulse)
            begin
                dly_cnt_r <= {CW{1'b0}};
                case (aux_level_and_options_r[`LDS_FORCE_MSB:`LDS_FORCE_LSB])
                    2'h0:
                    begin
                        mode_r <= `LDS_MODE_1X;
                        auto_r <= 1'b1;
                    end
                    2'h1:
                    begin
                        mode_r <= `LDS_MODE_1X5;
                        auto_r <= 1'b0;
                    end
                    default:
                    begin
                        mode_r <= `LDS_MODE_2X;
                        auto_r <= 1'b0;
                    end
                endcase
            end
            else if (!auto_r)
                dly_cnt_r <= {CW{1'b0}};
            else if (cam_d_r && !cam_sel)
            begin
                mode_r    <= `LDS_MODE_1X;
                dly_cnt_r <= {CW{1'b0}};
            end
            else if (!drop_s || mode_r == `LDS_MODE_2X || fault || all_zero)
                dly_cnt_r <= {CW{1'b0}};
            else if (dly_cnt_r >= dly_lim - 1'b1)
            begin
                mode_r    <= mode_r + 2'h1;
                dly_cnt_r <= {CW{1'b0}};
            end
            else
                dly_cnt_r <= dly_cnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------------
    // Faults force every source and the pump off; they come back as soon as
    // the fault input clears, so thermal cycling follows the sensor.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_dac  <= 8'h00;
            main_en   <= 1'b0;
            cam_dac   <= 4'h0;
            cam_en    <= 1'b0;
            aux_dac   <= 2'h0;
            aux_en    <= 1'b0;
            pump_mode <= `LDS_MODE_1X;
            pump_en   <= 1'b0;
            shutdown  <= 1'b1;
        end
        else
        begin
            main_dac <= main_led_level_r;
            cam_dac  <= cam_sel
                      ? camera_led_levels_r[`LDS_CAM_HI_MSB:`LDS_CAM_HI_LSB]
                      : camera_led_levels_r[`LDS_CAM_LO_MSB:`LDS_CAM_LO_LSB];
            aux_dac  <= aux_level_and_options_r[`LDS_AUX_MSB:`LDS_AUX_LSB];
            main_en  <= !fault && (main_led_level_r != 8'h00);
            cam_en   <= !fault && (cam_sel
                      ? camera_led_levels_r[`LDS_CAM_HI_MSB:`LDS_CAM_HI_LSB] != 4'h0
                      : camera_led_levels_r[`LDS_CAM_LO_MSB:`LDS_CAM_LO_LSB] != 4'h0);
            aux_en   <= !fault && (aux_level_and_options_r[`LDS_AUX_MSB:`LDS_AUX_LSB] != 2'h0);
            pump_en  <= !fault && !all_zero;
            pump_mode <= mode_r;
            shutdown <= all_zero;
        end
    end

endmodule

/* File: lds_serial_ctrl_monitor.sv */
// Checker for the LED driver serial control block, bound to its ports.
module lds_serial_ctrl_monitor
#(
    parameter DLY_LONG_CYC  = 200,
    parameter DLY_SHORT_CYC = 20
)
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       scl,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       over_temp,
    input wire logic       current_set_fault,
    input wire logic       dropout,
    input wire logic       main_en,
    input wire logic [3:0] cam_dac,
    input wire logic       cam_en,
    input wire logic       aux_en,
    input wire logic [1:0] pump_mode,
    input wire logic       pump_en,
    input wire logic       shutdown,
    input wire logic       load_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned drop_run_r;   // Consecutive cycles of dropout.
    logic [3:0]  load_hist_r;  // Recent load pulses, newest in bit 0.
    // Track the dropout run and recent loads.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drop_run_r  <= 0;
            load_hist_r <= 4'h0;
        end
        else
        begin
            drop_run_r  <= dropout ? drop_run_r + 1 : 0;
            load_hist_r <= {load_hist_r[2:0], load_pulse};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // A pump mode step that no load caused.
    sequence s_auto_step;
        $changed(pump_mode) && pump_mode != 2'h0 && load_hist_r == 4'h0;
    endsequence
    // Every enable is off.
    sequence s_all_off;
        !main_en && !cam_en && !aux_en && !pump_en;
    endsequence
    a_ack_drive_low: assert property (sda_oe |-> !sda_out) else $error("data driven high");
    a_ack_stable: assert property ($changed(sda_oe) |-> !scl) else $error("ack moved in high");
    a_load_single: assert property (load_pulse |=> !load_pulse) else $error("load too long");
    a_hot_all_off: assert property (over_temp [*6] |-> s_all_off) else $error("hot but on");
    a_setfault_off: assert property (current_set_fault [*6] |-> s_all_off) else $error("fault on");
    a_zero_all_off: assert property (shutdown |-> s_all_off) else $error("shutdown but on");
    a_cam_zero_off: assert property (cam_en |-> cam_dac != 4'h0) else $error("zero camera on");
    a_mode_code: assert property (pump_mode != 2'h3) else $error("bad pump mode");
    a_step_by_one: assert property (s_auto_step |-> pump_mode == $past(pump_mode) + 2'h1)
        else $error("pump skipped a mode");
    a_step_after_delay: assert property (s_auto_step |-> drop_run_r >= DLY_SHORT_CYC)
        else $error("pump stepped early");
endmodule
bind lds_serial_ctrl lds_serial_ctrl_monitor #(.DLY_LONG_CYC(DLY_LONG_CYC), .DLY_SHORT_CYC(DLY_SHORT_CYC)) u_mon
    (.ref_clk, .rst_n, .scl, .sda_out, .sda_oe, .over_temp, .current_set_fault, .dropout, .main_en,
     .cam_dac, .cam_en, .aux_en, .pump_mode, .pump_en, .shutdown, .load_pulse);

/* File: lds_host_master.sv */
// Host bus master model that drives the two-wire link of the block.
module lds_host_master
(
    output logic           scl,
    output logic           sda_pull,
    input  wire logic      sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real PH = 125.0;  // Each SCL phase in ns; the clock stands still between frames.
    initial scl = 1'h1;
    initial sda_pull = 1'h0;
    // START or repeated START: SDA falls while SCL is high.
    task start_c;
        #(PH / 2) sda_pull = 1'h0;
        #(PH / 2) scl = 1'h1;
        #(PH) sda_pull = 1'h1;
        #(PH) scl = 1'h0;
    endtask
    // STOP: SDA rises while SCL is high.
    task stop_c;
        #(PH / 2) sda_pull = 1'h1;
        #(PH / 2) scl = 1'h1;
        #(PH) sda_pull = 1'h0;
        #(PH);
    endtask
    // One byte MSB first, then the ack clock with SDA released; ack must be low at both ends of the high phase.
    task send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #(PH / 2) sda_pull = !b[i];
            #(PH / 2) scl = 1'h1;
            #(PH) scl = 1'h0;
        end
        #(PH / 2) sda_pull = 1'h0;
        #(PH / 2) scl = 1'h1;
        #1 ack = sda;
        #(PH - 2) ack = ack | sda;
        #1 scl = 1'h0;
    endtask
endmodule

/* File: lds_serial_ctrl_tb_top.sv */
// Self-checking testbench for the LED driver serial control block.
module lds_serial_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       ref_clk = 1'h0, rst_n = 1'h0, cam_sel = 1'h0;  // Clock, reset, level select.
    logic       ot = 1'h0, sf = 1'h0, drop = 1'h0;             // Fault and dropout inputs.
    wire        scl, m_pull, sda_out, sda_oe, main_en, cam_en, aux_en, pump_en, shutdown, load_pulse;
    wire  [7:0] main_dac;
    wire  [3:0] cam_dac;
    wire  [1:0] aux_dac, pump_mode;
    wire        sda = !(sda_oe | m_pull);  // Pulled-up data line.
    logic [3:0] acks;                      // Ack bits, address in bit 0.
    int         n_errors = 0, checks_done = 0, loads = 0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (load_pulse === 1'h1) loads++;
    lds_serial_ctrl #(.DLY_LONG_CYC(200), .DLY_SHORT_CYC(20)) dut
        (.ref_clk, .rst_n, .scl, .sda_in(sda), .sda_out, .sda_oe, .camera_level_select(cam_sel),
         .over_temp(ot), .current_set_fault(sf), .dropout(drop), .main_dac, .main_en, .cam_dac,
         .cam_en, .aux_dac, .aux_en, .pump_mode, .pump_en, .shutdown, .load_pulse);
    lds_host_master m (.scl, .sda_pull(m_pull), .sda);
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // START, address, n data bytes, and STOP if asked.
    task wr(input logic [7:0] ad, input logic [23:0] d, input int n, input bit stp);
        acks = 4'hF;
        m.start_c();
        m.send(ad, acks[0]);
        for (int i = 0; i < n; i++)
            m.send(d[23 - 8 * i -: 8], acks[i + 1]);
        if (stp)
            m.stop_c();
        tick(20);
    endtask
    task final_report;
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence of tests.
    initial
    begin
        tick(6);
        rst_n = 1'h1;
        tick(4);
        chk("shutdown", 8'(shutdown), 8'h01);
        chk("sda_oe", 8'(sda_oe), 8'h00);
        chk("sda_out", 8'(sda_out), 8'h00);
        wr(8'h36, 24'hA53C01, 3, 1);
        chk("acks", 8'(acks), 8'h00);
        chk("main_dac", main_dac, 8'hA5);
        chk("cam_dac", 8'(cam_dac), 8'h0C);
        chk("aux_dac", 8'(aux_dac), 8'h01);
        chk("enables", {4'h0, main_en, cam_en, aux_en, pump_en}, 8'h0F);
        chk("loads", 8'(loads), 8'h01);
        wr(8'h38, 24'h112233, 3, 1);
        chk("acks", 8'(acks), 8'h0F);
        wr(8'h37, 24'h112233, 3, 1);
        chk("acks", 8'(acks), 8'h0F);
        wr(8'h36, 24'h110000, 1, 1);
        chk("acks", 8'(acks), 8'h0C);
        chk("main_dac", main_dac, 8'hA5);
        wr(8'h36, 24'h778100, 3, 0);
        wr(8'h50, 24'h000000, 0, 1);
        chk("main_dac", main_dac, 8'h77);
        wr(8'h36, 24'h223300, 3, 0);
        wr(8'h36, 24'h990000, 1, 1);
        chk("main_dac", main_dac, 8'h77);
        $display("test bus finished");
        cam_sel = 1'h1;
        drop = 1'h1;
        tick(30);
        chk("cam_dac", 8'(cam_dac), 8'h08);
        chk("pump_mode", 8'(pump_mode), 8'h01);
        tick(25);
        chk("pump_mode", 8'(pump_mode), 8'h02);
        drop = 1'h0;
        cam_sel = 1'h0;
        tick(10);
        chk("pump_mode", 8'(pump_mode), 8'h00);
        drop = 1'h1;
        tick(150);
        chk("pump_mode", 8'(pump_mode), 8'h00);
        tick(70);
        chk("pump_mode", 8'(pump_mode), 8'h01);
        drop = 1'h0;
        wr(8'h36, 24'h778104, 3, 1);
        chk("pump_mode", 8'(pump_mode), 8'h00);
        drop = 1'h1;
        tick(30);
        chk("pump_mode", 8'(pump_mode), 8'h01);
        drop = 1'h0;
        wr(8'h36, 24'h77810C, 3, 1);
        drop = 1'h1;
        tick(60);
        chk("pump_mode", 8'(pump_mode), 8'h01);
        drop = 1'h0;
        wr(8'h36, 24'h778110, 3, 1);
        chk("pump_mode", 8'(pump_mode), 8'h02);
        $display("test pump finished");
        for (int k = 0; k < 2; k++)
        begin
            {ot, sf} = k ? 2'h1 : 2'h2;
            tick(8);
            chk("enables", {4'h0, main_en, cam_en, aux_en, pump_en}, 8'h00);
            {ot, sf} = 2'h0;
            tick(8);
            chk("enables", {4'h0, main_en, cam_en, aux_en, pump_en}, 8'h0D);
        end
        wr(8'h36, 24'h000000, 3, 1);
        chk("shutdown", 8'(shutdown), 8'h01);
        $display("test faults finished");
        final_report();
    end
    // Watchdog: the tests need about 13000 cycles.
    initial
    begin
        #(60000 * 8);
        n_errors++;
        final_report();
    end
endmodule
